// ==== pkg/nvm_cfg_pkg.sv ====
// Constants, register map and address decode for the fail-safe and diagnostics
// enable register bank.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.

package nvm_cfg_pkg;

    // ------------------------------------------------------------------------
    // Widths and sizes
    // ------------------------------------------------------------------------
    localparam int NUM_REGS = 6;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int HDATA_W = 32;
    localparam int NUM_CH = 12;
    localparam int SLOT_W = 3;

    // ------------------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ------------------------------------------------------------------------
    localparam logic [9:0] IDX_SAFE0_LO = 10'h0c0;
    localparam logic [9:0] IDX_SAFE0_HI = 10'h0c1;
    localparam logic [9:0] IDX_SAFE1_LO = 10'h0c2;
    localparam logic [9:0] IDX_SAFE1_HI = 10'h0c3;
    localparam logic [9:0] IDX_DIAG_LO = 10'h0c4;
    localparam logic [9:0] IDX_DIAG_HI = 10'h0c5;

    // ------------------------------------------------------------------------
    // Slots of the bank, in index order
    // ------------------------------------------------------------------------
    localparam logic [2:0] SLOT_SAFE0_LO = 3'h0;
    localparam logic [2:0] SLOT_SAFE0_HI = 3'h1;
    localparam logic [2:0] SLOT_SAFE1_LO = 3'h2;
    localparam logic [2:0] SLOT_SAFE1_HI = 3'h3;
    localparam logic [2:0] SLOT_DIAG_LO = 3'h4;
    localparam logic [2:0] SLOT_DIAG_HI = 3'h5;

    // ------------------------------------------------------------------------
    // Values after reset and writable bits
    // ------------------------------------------------------------------------
    localparam logic [7:0] RST_SAFE0_LO = 8'h00;
    localparam logic [7:0] RST_SAFE0_HI = 8'h00;
    localparam logic [7:0] RST_SAFE1_LO = 8'hff;
    localparam logic [7:0] RST_SAFE1_HI = 8'h0f;
    localparam logic [7:0] RST_DIAG_LO = 8'hff;
    localparam logic [7:0] RST_DIAG_HI = 8'h0f;
    localparam logic [7:0] WMASK_FULL = 8'hff;
    localparam logic [7:0] WMASK_NIBBLE = 8'h0f;

    localparam logic [7:0] RESET_TAB [NUM_REGS] = '{
        RST_SAFE0_LO, RST_SAFE0_HI, RST_SAFE1_LO, RST_SAFE1_HI, RST_DIAG_LO, RST_DIAG_HI
    };
    localparam logic [7:0] WMASK_TAB [NUM_REGS] = '{
        WMASK_FULL, WMASK_NIBBLE, WMASK_FULL, WMASK_NIBBLE, WMASK_FULL, WMASK_NIBBLE
    };

    // ------------------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------------------
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [1:0] BYTE_OFS_ZERO = 2'h0;

    // Maps a byte address to {hit, slot}; misaligned or outside the bank misses.
    function automatic logic [3:0] addr_slot(input logic [ADDR_W-1:0] addr);
        logic [9:0] idx;
        logic [9:0] ofs;
        idx = addr[ADDR_W-1:2];
        ofs = idx - IDX_SAFE0_LO;
        if ((addr[1:0] == BYTE_OFS_ZERO) && (idx >= IDX_SAFE0_LO) && (idx <= IDX_DIAG_HI)) begin
            addr_slot = {1'b1, ofs[SLOT_W-1:0]};
        end else begin
            addr_slot = 4'h0;
        end
    endfunction

endpackage

// ==== logic/cfg_reg.sv ====
// One byte-wide configuration register with a mask of writable bits.
// Assumes the write strobe is a single-cycle pulse on the same clock.

`timescale 1ns/1ps
`default_nettype none

module cfg_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] WMASK = 8'hff
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Write side
    input wire logic wr_en_i,
    input wire logic [7:0] wr_data_i,
    // Value
    output logic [7:0] q_o,
    output logic [7:0] next_o
);

    logic [7:0] q;
    logic [7:0] next_q;

    // ------------------------------------------------------------------------
    // Next value
    // ------------------------------------------------------------------------
    // Bits outside the mask never take a written value and stay at zero.
    always_comb begin
        next_q = q;
        if (wr_en_i) begin
            next_q = wr_data_i & WMASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= RESET_VAL;
        end else begin
            q <= next_q;
        end
    end

    assign q_o = q;
    assign next_o = next_q;

endmodule // cfg_reg

`default_nettype wire

// ==== logic/ahb_front.sv ====
// Address-phase capture of an AHB-Lite slave with no wait states.
// Assumes a single master; the slave's ready is the bus's ready.

`timescale 1ns/1ps
`default_nettype none

module ahb_front #(
    parameter int ADDR_W = nvm_cfg_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Address phase
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [ADDR_W-1:0] haddr_i,
    input wire logic hready_i,
    // Decoded transfer
    output logic take_o,
    output logic wr_pend_o,
    output logic [2:0] wr_slot_o
);

    logic wr_pend;
    logic [2:0] wr_slot;
    logic next_wr_pend;
    logic [2:0] next_wr_slot;
    logic [3:0] dec;

    // ------------------------------------------------------------------------
    // Address phase decode
    // ------------------------------------------------------------------------
    // A transfer is taken on any selected NONSEQ or SEQ with the bus ready.
    always_comb begin
        take_o = hsel_i && htrans_i[1] && hready_i;
        dec = nvm_cfg_pkg::addr_slot(haddr_i);
        next_wr_pend = take_o && hwrite_i && dec[3];
        next_wr_slot = take_o ? dec[2:0] : wr_slot;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend <= 1'b0;
            wr_slot <= 3'h0;
        end else begin
            wr_pend <= next_wr_pend;
            wr_slot <= next_wr_slot;
        end
    end

    assign wr_pend_o = wr_pend;
    assign wr_slot_o = wr_slot;

endmodule // ahb_front

`default_nettype wire

// ==== logic/failsafe_diag_regs.sv ====
// Bank of fail-safe channel enables and diagnostics enables for twelve channels,
// reached over AHB-Lite and driven out as per-channel enable vectors.
// Assumes one AHB-Lite master on REF_CLK_I and a single-slave bus.
//
// How it works
// RULE_01: Index C1h bits 3..0 enable channels 11..8 in fail-safe state 0, reset off.
// RULE_02: Index C2h bit n enables channel n in fail-safe state 1, reset all on.
// RULE_03: Index C3h bits 3..0 enable channels 11..8 in fail-safe state 1, reset on.
// RULE_04: Index C4h bit n enables diagnostics on channel n, reset all on.
// RULE_05: Every enable bit reads 0 for disabled and 1 for enabled.
// RULE_06: Upper nibble of both upper fail-safe registers reads zero, writes ignored.
// RULE_07: Index C0h bit n enables channel n in fail-safe state 0, reset off.
// RULE_08: Index C5h bits 3..0 enable diagnostics on channels 8..11, reset on; the code maps bit 3 to channel 11 and bit 0 to channel 8.
//
// The implementer's own choice: the AHB-Lite slave port.

`timescale 1ns/1ps
`default_nettype none

module failsafe_diag_regs #(
    parameter int ADDR_W = nvm_cfg_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [ADDR_W-1:0] HADDR_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Channel enables
    output logic [11:0] SAFE0_EN_O,
    output logic [11:0] SAFE1_EN_O,
    output logic [11:0] DIAG_ON_O
);

    localparam int NR = nvm_cfg_pkg::NUM_REGS;

    logic take;
    logic wr_pend;
    logic [2:0] wr_slot;
    logic [7:0] reg_q [NR];
    logic [7:0] reg_next [NR];
    logic [NR-1:0] wr_en;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [3:0] rd_dec;

    // ------------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------------
    ahb_front #(
        .ADDR_W(ADDR_W)
    ) u_front (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .hsel_i(HSEL_I),
        .htrans_i(HTRANS_I),
        .hwrite_i(HWRITE_I),
        .haddr_i(HADDR_I),
        .hready_i(HREADY_I),
        .take_o(take),
        .wr_pend_o(wr_pend),
        .wr_slot_o(wr_slot)
    );

    // The bank never stalls and never signals an error, whatever the address.
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = nvm_cfg_pkg::HRESP_OKAY;

    // ------------------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------------------
    // A write lands at the end of its data phase; unmapped writes were dropped.
    always_comb begin
        for (int i = 0; i < NR; i++) begin
            wr_en[i] = wr_pend && (wr_slot == i[2:0]);
        end
    end

    // ------------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------------
    // Reset values and writable masks come from per-slot tables. [RULE_05]
    for (genvar g = 0; g < NR; g++) begin : g_reg
        cfg_reg #(
            .RESET_VAL(nvm_cfg_pkg::RESET_TAB[g]), // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
            .WMASK(nvm_cfg_pkg::WMASK_TAB[g])      // [RULE_06] [RULE_07] [RULE_08]
        ) u_reg (
            .clk_i(REF_CLK_I),
            .rst_n_i(RST_N_I),
            .wr_en_i(wr_en[g]),
            .wr_data_i(HWDATA_I[7:0]),
            .q_o(reg_q[g]),
            .next_o(reg_next[g])
        );
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Read data is captured at the address-phase edge from the next register
    // values, so a read right behind a write sees the written data.
    always_comb begin
        rd_dec = nvm_cfg_pkg::addr_slot(HADDR_I);
        next_rdata = rdata;
        if (take && !HWRITE_I) begin
            next_rdata = 32'h0;
            if (rd_dec[3]) begin
                next_rdata = {24'h0, reg_next[rd_dec[2:0]]}; // [RULE_06]
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata <= 32'h0;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign HRDATA_O = rdata;

    // ------------------------------------------------------------------------
    // Channel enable vectors
    // ------------------------------------------------------------------------
    // Bit n of each vector is channel n; 1 means enabled. [RULE_05]
    assign SAFE0_EN_O = {reg_q[nvm_cfg_pkg::SLOT_SAFE0_HI][3:0],
                         reg_q[nvm_cfg_pkg::SLOT_SAFE0_LO]}; // [RULE_01] [RULE_07]
    assign SAFE1_EN_O = {reg_q[nvm_cfg_pkg::SLOT_SAFE1_HI][3:0],
                         reg_q[nvm_cfg_pkg::SLOT_SAFE1_LO]}; // [RULE_02] [RULE_03]
    assign DIAG_ON_O = {reg_q[nvm_cfg_pkg::SLOT_DIAG_HI][3:0],
                        reg_q[nvm_cfg_pkg::SLOT_DIAG_LO]};   // [RULE_04] [RULE_08]

endmodule // failsafe_diag_regs

`default_nettype wire

// ==== verif/fdr_assertions.sv ====
// Concurrent checks on the ports of the fail-safe and diagnostics enable bank.
// Assumes the bus ready input is fed from the bank's own ready output.

`timescale 1ns/1ps
`default_nettype none

module fdr_checker #(
    parameter int ADDR_W = nvm_cfg_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Bus
    input wire logic HSEL_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [ADDR_W-1:0] HADDR_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    // Enables
    input wire logic [11:0] SAFE0_EN_O,
    input wire logic [11:0] SAFE1_EN_O,
    input wire logic [11:0] DIAG_ON_O
);
    logic wr_take;
    logic rd_take;
    assign wr_take = HSEL_I && HTRANS_I[1] && HREADY_I && HWRITE_I;
    assign rd_take = HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;

    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    bus_answer_a: assert property (
        HREADYOUT_O && !HRESP_O && HRDATA_O[31:8] == 24'h0) else $error("bus answer wrong");
    reset_values_a: assert property (
        $rose(RST_N_I) |-> SAFE0_EN_O == 12'h000 && SAFE1_EN_O == 12'hfff && DIAG_ON_O == 12'hfff)
        else $error("enables wrong after reset");
    safe0_write_a: assert property (
        wr_take && HADDR_I == 12'h300 |=> ##1 SAFE0_EN_O[7:0] == $past(HWDATA_I[7:0]))
        else $error("fail-safe 0 low write lost");
    safe1_hi_write_a: assert property (
        wr_take && HADDR_I == 12'h30c |=> ##1 SAFE1_EN_O[11:8] == $past(HWDATA_I[3:0]))
        else $error("fail-safe 1 high write lost");
    diag_write_a: assert property (
        wr_take && HADDR_I == 12'h310 |=> ##1 DIAG_ON_O[7:0] == $past(HWDATA_I[7:0]))
        else $error("diagnostics write lost");
    safe1_read_a: assert property (
        rd_take && HADDR_I == 12'h308 |=> HRDATA_O == {24'h0, SAFE1_EN_O[7:0]})
        else $error("fail-safe 1 low read wrong");
    safe0_hi_read_a: assert property (
        rd_take && HADDR_I == 12'h304 |=> HRDATA_O == {28'h0, SAFE0_EN_O[11:8]})
        else $error("fail-safe 0 high read wrong");
    miss_read_a: assert property (
        rd_take && (HADDR_I[1:0] != 2'h0 || HADDR_I > 12'h314) |=> HRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    enables_hold_a: assert property (
        !wr_take |=> ##1 $stable({SAFE0_EN_O, SAFE1_EN_O, DIAG_ON_O}))
        else $error("enables changed without a write");
endmodule // fdr_checker

bind failsafe_diag_regs fdr_checker #(.ADDR_W(ADDR_W)) chk_inst (.REF_CLK_I(REF_CLK_I),
    .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HADDR_I(HADDR_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .SAFE0_EN_O(SAFE0_EN_O),
    .SAFE1_EN_O(SAFE1_EN_O), .DIAG_ON_O(DIAG_ON_O));

`default_nettype wire

// ==== verif/failsafe_diag_enable_nvm_regs_tb.sv ====
// Self-checking bench for the enable bank, with a byte model of each register.
// Assumes a bank that answers without wait states, one word per register.

`timescale 1ns/1ps
`default_nettype none

module failsafe_diag_enable_nvm_regs_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic [11:0] safe0, safe1, diag;
    logic [31:0] seed = 32'h1095;
    logic [7:0] model [6];
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    failsafe_diag_regs failsafe_diag_regs_inst (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .HSEL_I(hsel), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
        .HADDR_I(haddr), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(), .SAFE0_EN_O(safe0), .SAFE1_EN_O(safe1),
        .DIAG_ON_O(diag));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One single transfer: address phase, then data phase, each held until ready.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    initial begin
        logic [31:0] rd;
        logic [31:0] wd;
        logic [11:0] a;
        logic hit;
        int i;
        for (int r = 0; r < 2; r++) begin
            rst_n <= 1'b0;
            repeat (16) @(posedge clk);
            rst_n <= 1'b1;
            @(posedge clk);
            model = '{8'h00, 8'h00, 8'hff, 8'h0f, 8'hff, 8'h0f};
            for (int k = 0; k < ((r == 0) ? 90 : 6); k++) begin
                seed = xorshift(seed);
                i = (k < 18) ? k % 6 : int'(seed[10:8]) % 6;
                wd = (k < 12) ? 32'hffffffff : ((k < 18) ? 32'h0 : seed);
                a = 12'h300 + 12'(4 * i);
                if (k >= 18 && (seed[3:0] == 4'h0 || k % 16 == 2)) begin
                    a = seed[4] ? 12'h318 : 12'h302;
                end
                hit = (a[1:0] == 2'h0) && (a < 12'h318);
                if (k >= 6) begin
                    xfer(1'b1, a, wd, rd);
                    if (hit) begin
                        model[i] = wd[7:0] & ((i % 2 == 1) ? 8'h0f : 8'hff);
                    end
                end
                xfer(1'b0, a, 32'h0, rd);
                check("read data", rd, hit ? {24'h0, model[i]} : 32'h0);
                check("safe0", 32'(safe0), 32'({model[1][3:0], model[0]}));
                check("safe1", 32'(safe1), 32'({model[3][3:0], model[2]}));
                check("diag", 32'(diag), 32'({model[5][3:0], model[4]}));
            end
        end
        tally_and_finish();
    end
endmodule // failsafe_diag_enable_nvm_regs_tb

`default_nettype wire
